/* File: src/hir_if.sv */
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------------------
// Two-wire bus with pull-ups: a line is low while any end enables its driver.
// ------------------------------------------------------------------------
interface hir_if;
  logic m_scl_o;
  logic m_scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic d_sda_o;
  logic d_sda_oe;
  logic scl_line;
  logic sda_line;

  // Resolved wire levels; nobody ever drives a line high.
  assign scl_line = ~(m_scl_oe & ~m_scl_o);
  assign sda_line = ~(m_sda_oe & ~m_sda_o) & ~(d_sda_oe & ~d_sda_o);

  modport master (output m_scl_o, m_scl_oe, m_sda_o, m_sda_oe, input scl_line, sda_line);
  modport device (output d_sda_o, d_sda_oe, input scl_line, sda_line);
endinterface

`default_nettype wire

/* File: src/hir_master.sv */
`timescale 1ns/1ps
`default_nettype none

module hir_master
  import hir_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Bus side
  hir_if.master            bus
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic        scl_s1;
    logic        scl_s2;
    logic        sda_s1;
    logic        sda_s2;
    hir_mst_t    step;
    logic [1:0]  q;
    logic [7:0]  qc;
    logic [3:0]  bitc;
    logic [7:0]  shreg;
    logic        stop;
    logic        rd;
    logic        nack;
    logic        busy;
    logic        got_nack;
    logic        scl_oe;
    logic        sda_oe;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } hir_mstate_t;

  hir_mstate_t m_r;
  hir_mstate_t m_nxt;

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  // Each bit is four quarter periods: set SDA, raise SCL, sample, lower SCL,
  // so SDA moves while SCL is low, except the ACK release, which is made in the cycle that SCL is pulled low.
  always_comb begin
    logic tick;
    logic acc;
    tick  = m_r.busy && m_r.qc == QTR_LAST;
    acc   = psel & penable & m_r.pready;
    m_nxt = m_r;

    m_nxt.scl_s1 = bus.scl_line;
    m_nxt.scl_s2 = m_r.scl_s1;
    m_nxt.sda_s1 = bus.sda_line;
    m_nxt.sda_s2 = m_r.sda_s1;
    m_nxt.qc     = (m_r.busy && !tick) ? 8'(m_r.qc + 8'h01) : 8'h00;
    m_nxt.pready = 1'b1;

    // APB: answer prepared in the setup cycle, zero wait states.
    if (psel && !penable) begin
      m_nxt.pslverr = (paddr != APB_CMD) && (paddr != APB_STAT);
      m_nxt.prdata  = 32'h0000_0000;
      if (paddr == APB_STAT) begin
        m_nxt.prdata[STAT_BUSY]                = m_r.busy;
        m_nxt.prdata[STAT_NACK]                = m_r.got_nack;
        m_nxt.prdata[STAT_SCL]                 = m_r.scl_s2;
        m_nxt.prdata[STAT_SDA]                 = m_r.sda_s2;
        m_nxt.prdata[DATA_LSB +: 8]            = m_r.shreg;
      end
    end

    // A command while busy is dropped; software polls busy first.
    if (acc && pwrite && paddr == APB_CMD && !m_r.busy) begin
      m_nxt.busy     = 1'b1;
      m_nxt.stop     = pwdata[CMD_STOP];
      m_nxt.rd       = pwdata[CMD_READ];
      m_nxt.nack     = pwdata[CMD_NACK];
      m_nxt.got_nack = 1'b0;
      m_nxt.shreg    = pwdata[DATA_LSB +: 8];
      m_nxt.step     = pwdata[CMD_START] ? MS_START : MS_BIT;     // R10 R14
      m_nxt.q        = 2'h0;
      m_nxt.bitc     = 4'h0;
    end else if (tick) begin
      m_nxt.q = 2'(m_r.q + 2'h1);
      unique case (m_r.step)
        MS_IDLE: begin
          m_nxt.busy = 1'b0;
        end
        MS_START: begin
          // Works from idle and as a repeated START with SCL held low.
          unique case (m_r.q)
            2'h0: m_nxt.sda_oe = 1'b0;
            2'h1: m_nxt.scl_oe = 1'b0;
            2'h2: m_nxt.sda_oe = 1'b1;                            // R7
            2'h3: begin
              m_nxt.scl_oe = 1'b1;
              m_nxt.step   = MS_BIT;
            end
          endcase
        end
        MS_BIT: begin
          unique case (m_r.q)
            2'h0: begin
              if (m_r.bitc != BYTE_BITS) begin
                m_nxt.sda_oe = ~m_r.rd & ~m_r.shreg[7];          // R5 R6
              end else begin
                m_nxt.sda_oe = m_r.rd & ~m_r.nack;                // R11
              end
            end
            2'h1: m_nxt.scl_oe = 1'b0;
            2'h2: begin
              if (m_r.bitc != BYTE_BITS) begin
                m_nxt.shreg = {m_r.shreg[6:0], m_r.sda_s2};
              end else if (!m_r.rd) begin
                m_nxt.got_nack = m_r.sda_s2;                      // R9
              end
            end
            2'h3: begin
              m_nxt.scl_oe = 1'b1;
              if (m_r.bitc == BYTE_BITS) begin
                m_nxt.sda_oe = 1'b0;
                m_nxt.step   = m_r.stop ? MS_STOP : MS_IDLE;
                m_nxt.busy   = m_r.stop;
              end else begin
                m_nxt.bitc = 4'(m_r.bitc + 4'h1);
              end
            end
          endcase
        end
        MS_STOP: begin
          unique case (m_r.q)
            2'h0: m_nxt.sda_oe = 1'b1;
            2'h1: m_nxt.scl_oe = 1'b0;
            2'h2: m_nxt.sda_oe = 1'b0;                            // R7 R11
            2'h3: begin
              m_nxt.step = MS_IDLE;
              m_nxt.busy = 1'b0;
            end
          endcase
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      m_r        <= '0;
      m_r.scl_s1 <= 1'b1;
      m_r.scl_s2 <= 1'b1;
      m_r.sda_s1 <= 1'b1;
      m_r.sda_s2 <= 1'b1;
    end else begin
      m_r <= m_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // Open drain: the level is low and only the enables move.
  assign bus.m_scl_o  = 1'b0;                                     // R2
  assign bus.m_scl_oe = m_r.scl_oe;
  assign bus.m_sda_o  = 1'b0;
  assign bus.m_sda_oe = m_r.sda_oe;
  assign prdata       = m_r.prdata;
  assign pready       = m_r.pready;
  assign pslverr      = m_r.pslverr;

endmodule // hir_master

`default_nettype wire

/* File: src/hir_pkg.sv */
package hir_pkg;

  // ----------------------------------------------------------------------
  // Clocking and bus timing
  // ----------------------------------------------------------------------
  localparam int          CLK_HZ     = 100_000_000;
  localparam int          SCL_HZ     = 1_000_000;
  localparam int          QTR_CYC    = CLK_HZ / (4 * SCL_HZ);
  localparam logic [7:0]  QTR_LAST   = 8'(QTR_CYC - 1);
  localparam logic [1:0]  FILT_LAST  = 2'h3;
  localparam logic [3:0]  BYTE_BITS  = 4'h8;

  // ----------------------------------------------------------------------
  // Device register map, reset values and writable masks
  // ----------------------------------------------------------------------
  localparam logic [7:0]  REG_REV    = 8'h00;
  localparam logic [7:0]  REG_EVMAIN = 8'h03;
  localparam logic [7:0]  REG_EVWARN = 8'h04;
  localparam logic [7:0]  REG_EVSEQ  = 8'h05;
  localparam logic [7:0]  REG_LIVE   = 8'h06;
  localparam logic [7:0]  REG_MASK   = 8'h07;
  localparam logic [7:0]  REG_CFG    = 8'h08;
  localparam logic [7:0]  REG_BASE   = 8'h09;
  localparam logic [7:0]  REG_PERH   = 8'h0a;
  localparam logic [7:0]  REG_PERL   = 8'h0b;
  localparam logic [7:0]  RST_CFG    = 8'h40;
  localparam logic [6:0]  RST_BASE   = 7'h4a;
  localparam logic [7:0]  RST_PERH   = 8'h21;
  localparam logic [6:0]  RST_PERL   = 7'h4f;
  localparam logic [7:0]  MSK_EVWARN = 8'hd8;
  localparam logic [7:0]  MSK_EVSEQ  = 8'he0;
  localparam logic [7:0]  MSK_CFG    = 8'hc0;
  localparam int          CFG_WRMODE = 7;
  localparam int          CFG_TOEN   = 6;

  // ----------------------------------------------------------------------
  // Controller registers on APB
  // ----------------------------------------------------------------------
  localparam logic [11:0] APB_CMD    = 12'h000;
  localparam logic [11:0] APB_STAT   = 12'h004;
  localparam int          CMD_START  = 0;
  localparam int          CMD_STOP   = 1;
  localparam int          CMD_READ   = 2;
  localparam int          CMD_NACK   = 3;
  localparam int          DATA_LSB   = 8;
  localparam int          STAT_BUSY  = 0;
  localparam int          STAT_NACK  = 1;
  localparam int          STAT_SCL   = 2;
  localparam int          STAT_SDA   = 3;

  // ----------------------------------------------------------------------
  // State encodings
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    SS_IDLE = 3'h0, SS_RX = 3'h1, SS_ACK = 3'h2, SS_TX = 3'h3, SS_MACK = 3'h4
  } hir_sst_t;
  typedef enum logic [1:0] {
    KIND_ADDR = 2'h0, KIND_REG = 2'h1, KIND_DATA = 2'h2
  } hir_kind_t;
  typedef enum logic [1:0] {
    MS_IDLE = 2'h0, MS_START = 2'h1, MS_BIT = 2'h2, MS_STOP = 2'h3
  } hir_mst_t;

endpackage

/* File: src/hir_slave.sv */
// Behaviour
// R1: Device is slave only, never a master.
// R2: Works at any SCL up to 1 MHz.
// R3: Follows master clock, never stretches SCL.
// R4: Only pulls SDA low or releases it.
// R5: SDA changes only while SCL is low.
// R6: Bytes are eight bits, MSB first.
// R7: START and STOP detected while SCL high.
// R8: Acknowledge own slave address at once.
// R9: Write: address, register, data, each acknowledged.
// R10: Master writes register address before reading.
// R11: Master ends a read with NACK, STOP.
// R12: Page read increments pointer on master ACK.
// R13: Unimplemented registers read as zero.
// R14: Same slave address after repeated START.
// R15: Page write stores at incrementing addresses.
// R16: Repeat mode writes to last received address.
// R17: START or STOP mid message returns idle.
// R18: Mode 0 page and repeat; mode 1 repeat. Here mode 0 (cfg bit 7 clear) does page only, mode 1 repeat.
// R19: Reserved bits read-only, writes ignored.
// R20: Address is base[6:2] plus select pins.
// R21: Synchronise and glitch-filter SCL and SDA.
// R22: Writes to empty addresses acknowledged, ignored.
`timescale 1ns/1ps
`default_nettype none

module hir_slave
  import hir_pkg::*;
#(
  parameter logic [7:0] REV_CODE = 8'h11  // Arbitrary revision value.
) (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Bus side
  hir_if.device           bus,
  // Address select pins
  input  wire logic [1:0] addr_sel,
  // Event and status sources from the driver core
  input  wire logic [7:0] evt_main,
  input  wire logic [7:0] evt_warn,
  input  wire logic [7:0] evt_seq,
  input  wire logic [7:0] live_status,
  // Configuration towards the driver core
  output logic [7:0]      event_mask,
  output logic [14:0]     resonance_period,
  output logic            bus_timeout_enable
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic       scl_s1;
    logic       scl_s2;
    logic       sda_s1;
    logic       sda_s2;
    logic       scl_f;
    logic       sda_f;
    logic [1:0] scl_c;
    logic [1:0] sda_c;
    logic [1:0] asel_s1;
    logic [1:0] asel_s2;
    hir_sst_t   st;
    hir_kind_t  kind;
    logic       rw;
    logic [3:0] bitc;
    logic [7:0] shreg;
    logic [7:0] ptr;
    logic       sda_oe;
    logic [7:0] ev_main;
    logic [7:0] ev_warn;
    logic [7:0] ev_seq;
    logic [7:0] mask;
    logic [7:0] cfg;
    logic [6:0] base;
    logic [7:0] perh;
    logic [6:0] perl;
  } hir_sstate_t;

  hir_sstate_t s_r;
  hir_sstate_t s_nxt;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // A filtered level follows its input only after it has held for a few
  // clocks, so ringing on a slow edge cannot fake a START or a bit.
  function automatic logic [2:0] filt(input logic in, input logic lvl, input logic [1:0] cnt);
    logic [2:0] r;
    r = {lvl, 2'h0};
    if (in != lvl) begin
      if (cnt == FILT_LAST) begin
        r = {in, 2'h0};
      end else begin
        r = {lvl, 2'(cnt + 2'h1)};
      end
    end
    return r;
  endfunction

  // Read view of the map; holes and reserved bits read as zero.
  function automatic logic [7:0] rd_byte(input hir_sstate_t r, input logic [7:0] a);
    logic [7:0] d;
    d = 8'h00;                                                    // R13
    unique case (a)
      REG_REV:    d = REV_CODE;
      REG_EVMAIN: d = r.ev_main;
      REG_EVWARN: d = r.ev_warn;
      REG_EVSEQ:  d = r.ev_seq;
      REG_LIVE:   d = live_status;
      REG_MASK:   d = r.mask;
      REG_CFG:    d = r.cfg;
      REG_BASE:   d = {1'b0, r.base};
      REG_PERH:   d = r.perh;
      REG_PERL:   d = {1'b0, r.perl};
      default:    d = 8'h00;                                      // R13
    endcase
    return d;
  endfunction

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  // Everything is sampled on pclk; the bus clock is only an input, so
  // the slave cannot hold SCL and simply keeps pace with the master.
  always_comb begin
    logic [2:0] fs;
    logic [2:0] fd;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_c;
    logic       stop_c;
    logic       we;
    logic [7:0] wa;
    logic [7:0] wd;
    logic [7:0] clr_main;
    logic [7:0] clr_warn;
    logic [7:0] clr_seq;
    logic [7:0] rb;
    fs       = 3'h0;
    fd       = 3'h0;
    we       = 1'b0;
    wa       = s_r.ptr;
    wd       = s_r.shreg;
    clr_main = 8'h00;
    clr_warn = 8'h00;
    clr_seq  = 8'h00;
    rb       = rd_byte(s_r, s_r.ptr);
    s_nxt    = s_r;

    // Two-stage synchronisers, then the glitch filter on the second stage.
    s_nxt.scl_s1  = bus.scl_line;                                 // R3 R21
    s_nxt.scl_s2  = s_r.scl_s1;
    s_nxt.sda_s1  = bus.sda_line;
    s_nxt.sda_s2  = s_r.sda_s1;
    s_nxt.asel_s1 = addr_sel;
    s_nxt.asel_s2 = s_r.asel_s1;
    fs            = filt(s_r.scl_s2, s_r.scl_f, s_r.scl_c);       // R21
    fd            = filt(s_r.sda_s2, s_r.sda_f, s_r.sda_c);
    s_nxt.scl_f   = fs[2];
    s_nxt.scl_c   = fs[1:0];
    s_nxt.sda_f   = fd[2];
    s_nxt.sda_c   = fd[1:0];

    // Bus events seen on the filtered lines.
    scl_rise = ~s_r.scl_f & s_nxt.scl_f;
    scl_fall = s_r.scl_f & ~s_nxt.scl_f;
    start_c  = s_r.scl_f & s_nxt.scl_f & s_r.sda_f & ~s_nxt.sda_f; // R7
    stop_c   = s_r.scl_f & s_nxt.scl_f & ~s_r.sda_f & s_nxt.sda_f; // R7

    // Message sequencer; the slave only ever answers, it never opens a
    // transfer of its own.
    if (start_c) begin                                            // R1
      // Any START abandons what was going on and listens for an address.
      s_nxt.st     = SS_RX;                                       // R17
      s_nxt.kind   = KIND_ADDR;
      s_nxt.bitc   = 4'h0;
      s_nxt.sda_oe = 1'b0;
    end else if (stop_c) begin
      s_nxt.st     = SS_IDLE;                                     // R17
      s_nxt.sda_oe = 1'b0;
    end else begin
      unique case (s_r.st)
        SS_IDLE: begin
        end
        SS_RX: begin
          if (scl_rise) begin
            s_nxt.shreg = {s_r.shreg[6:0], s_r.sda_f};            // R5 R6
            s_nxt.bitc  = 4'(s_r.bitc + 4'h1);
          end else if (scl_fall && s_r.bitc == BYTE_BITS) begin
            s_nxt.bitc = 4'h0;
            if (s_r.kind == KIND_ADDR) begin
              if (s_r.shreg[7:1] == {s_r.base[6:2], s_r.asel_s2}) begin // R20
                s_nxt.sda_oe = 1'b1;                              // R8
                s_nxt.rw     = s_r.shreg[0];
                s_nxt.st     = SS_ACK;
              end else begin
                s_nxt.st = SS_IDLE;
              end
            end else if (s_r.kind == KIND_REG) begin
              s_nxt.ptr    = s_r.shreg;
              s_nxt.kind   = KIND_DATA;
              s_nxt.sda_oe = 1'b1;                                // R9
              s_nxt.st     = SS_ACK;
            end else begin
              we           = 1'b1;                                // R9 R22
              s_nxt.sda_oe = 1'b1;
              s_nxt.st     = SS_ACK;
              if (s_r.cfg[CFG_WRMODE]) begin
                s_nxt.kind = KIND_REG;                            // R16 R18
              end else begin
                s_nxt.ptr = 8'(s_r.ptr + 8'h01);                  // R15
              end
            end
          end
        end
        SS_ACK: begin
          if (scl_fall) begin
            if (s_r.kind == KIND_ADDR && s_r.rw) begin
              // First data bit goes out on the same low phase.
              s_nxt.shreg  = rb;
              s_nxt.sda_oe = ~rb[7];                              // R4 R5
              s_nxt.bitc   = 4'h0;
              s_nxt.st     = SS_TX;
            end else begin
              if (s_r.kind == KIND_ADDR) begin
                s_nxt.kind = KIND_REG;
              end
              s_nxt.sda_oe = 1'b0;
              s_nxt.st     = SS_RX;
            end
          end
        end
        SS_TX: begin
          if (scl_rise) begin
            s_nxt.bitc = 4'(s_r.bitc + 4'h1);
          end else if (scl_fall) begin
            if (s_r.bitc == BYTE_BITS) begin
              s_nxt.sda_oe = 1'b0;
              s_nxt.bitc   = 4'h0;
              s_nxt.st     = SS_MACK;
            end else begin
              s_nxt.shreg  = {s_r.shreg[6:0], 1'b0};             // R6
              s_nxt.sda_oe = ~s_r.shreg[6];                       // R4 R5
            end
          end
        end
        SS_MACK: begin
          if (scl_rise) begin
            if (s_r.sda_f) begin
              s_nxt.st = SS_IDLE;
            end else begin
              // Acknowledged: reload on the next falling edge.
              if (!s_r.cfg[CFG_WRMODE]) begin
                s_nxt.ptr = 8'(s_r.ptr + 8'h01);                  // R12 R18
              end
              s_nxt.kind = KIND_ADDR;
              s_nxt.st   = SS_ACK;
            end
          end
        end
        default: begin
          s_nxt.st     = SS_IDLE;
          s_nxt.sda_oe = 1'b0;
        end
      endcase
    end

    // Register writes; only writable bits change, holes are ignored.
    if (we) begin
      unique case (wa)
        REG_EVMAIN: clr_main = wd;
        REG_EVWARN: clr_warn = wd & MSK_EVWARN;                   // R19
        REG_EVSEQ:  clr_seq = wd & MSK_EVSEQ;                     // R19
        REG_MASK:   s_nxt.mask = wd;
        REG_CFG:    s_nxt.cfg = (s_r.cfg & ~MSK_CFG) | (wd & MSK_CFG); // R19
        REG_BASE:   s_nxt.base = wd[6:0];
        REG_PERH:   s_nxt.perh = wd;
        REG_PERL:   s_nxt.perl = wd[6:0];
        default: begin                                            // R22
        end
      endcase
    end

    // Sticky events: a new event in the clearing cycle is kept.
    s_nxt.ev_main = (s_r.ev_main & ~clr_main) | evt_main;
    s_nxt.ev_warn = (s_r.ev_warn & ~clr_warn) | (evt_warn & MSK_EVWARN);
    s_nxt.ev_seq  = (s_r.ev_seq & ~clr_seq) | (evt_seq & MSK_EVSEQ);
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  // Synchronisers and filters reset high so release is not read as START.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r        <= '0;
      s_r.scl_s1 <= 1'b1;
      s_r.scl_s2 <= 1'b1;
      s_r.sda_s1 <= 1'b1;
      s_r.sda_s2 <= 1'b1;
      s_r.scl_f  <= 1'b1;
      s_r.sda_f  <= 1'b1;
      s_r.cfg    <= RST_CFG;
      s_r.base   <= RST_BASE;
      s_r.perh   <= RST_PERH;
      s_r.perl   <= RST_PERL;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // The driven level is always low; only the enable moves.
  assign bus.d_sda_o        = 1'b0;                               // R4
  assign bus.d_sda_oe       = s_r.sda_oe;
  assign event_mask         = s_r.mask;
  assign resonance_period   = {s_r.perh, s_r.perl};
  assign bus_timeout_enable = s_r.cfg[CFG_TOEN];

endmodule // hir_slave

`default_nettype wire

/* File: verif/haptic_i2c_register_slave_bench.sv */
`timescale 1ns/1ps
`default_nettype none

// ----
// Bench
// ----
module haptic_i2c_register_slave_bench;
  import hir_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [1:0]  addr_sel = 2'h0;
  logic [7:0]  evt_main = 8'h00;
  logic [7:0]  live_status = 8'h00;
  logic [7:0]  event_mask;
  logic [14:0] res_per;
  logic        to_en;
  logic [7:0]  mdl [0:15];
  logic [31:0] s;
  logic [7:0]  d [$];
  int          err_total = 0;
  int          cmp_count = 0;

  // Free-running system clock.
  always #5 pclk = ~pclk;

  hir_if hir_if_i ();
  // Revision value is arbitrary.
  hir_slave #(.REV_CODE(8'h5c)) hir_slave_i (.pclk, .presetn, .bus(hir_if_i), .addr_sel,
    .evt_main, .evt_warn(evt_main), .evt_seq(evt_main), .live_status, .event_mask,
    .resonance_period(res_per), .bus_timeout_enable(to_en));
  hir_master hir_master_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .bus(hir_if_i));
  hir_monitor hir_monitor_i (.pclk, .presetn, .m_scl_o(hir_if_i.m_scl_o),
    .m_scl_oe(hir_if_i.m_scl_oe), .m_sda_o(hir_if_i.m_sda_o), .m_sda_oe(hir_if_i.m_sda_oe),
    .d_sda_o(hir_if_i.d_sda_o), .d_sda_oe(hir_if_i.d_sda_oe), .scl_line(hir_if_i.scl_line),
    .sda_line(hir_if_i.sda_line));

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Expected register contents after a write, kept apart from the device.
  function automatic void upd(input logic [7:0] p, input logic [7:0] v);
    case (p)
      REG_EVMAIN, REG_EVWARN, REG_EVSEQ: mdl[p] = mdl[p] & ~v;
      REG_MASK, REG_PERH: mdl[p] = v;
      REG_CFG: mdl[p] = v & MSK_CFG;
      REG_PERL: mdl[p] = v & 8'h7f;
      default: ;
    endcase
  endfunction

  function automatic logic [7:0] sad(input logic r);
    return {RST_BASE[6:2], addr_sel, r};
  endfunction

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    s = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // One byte on the link; flags are nack, read, stop, start. Polls until idle.
  task automatic tx(input logic [7:0] b, input logic [3:0] f, input logic nk);
    apb(1'b1, APB_CMD, {16'h0000, b, 4'h0, f});
    s = 32'h0000_0001;
    while (s[STAT_BUSY] !== 1'b0) apb(1'b0, APB_STAT, 32'h0000_0000);
    if (!f[2]) chk("ack", 16'(nk), 16'(s[STAT_NACK]));
  endtask

  task automatic wr(input logic [7:0] rg);
    tx(sad(1'b0), 4'h1, 1'b0);
    tx(rg, 4'h0, 1'b0);
    foreach (d[i]) begin
      tx(d[i], {2'b00, i == d.size() - 1, 1'b0}, 1'b0);
      upd(rg + 8'(i), d[i]);
    end
  endtask

  task automatic rd(input logic [7:0] rg, input int n);
    tx(sad(1'b0), 4'h1, 1'b0);
    tx(rg, 4'h0, 1'b0);
    tx(sad(1'b1), 4'h1, 1'b0);
    for (int i = 0; i < n; i++) begin
      tx(8'h00, (i == n - 1) ? 4'he : 4'h4, 1'b0);
      chk("rdata", 16'(mdl[rg + (mdl[REG_CFG][CFG_WRMODE] ? 0 : i)]), 16'(s[15:8]));
    end
  endtask

  // A hang in any wait ends the run as a mismatch.
  initial begin
    repeat (90000) @(posedge pclk);
    err_total++;
    give_verdict();
  end

  initial begin
    void'($urandom(32'h0000_3b81));
    mdl = '{default: 8'h00};
    mdl[0] = 8'h5c;
    mdl[3] = 8'($urandom) | 8'h01;
    mdl[4] = mdl[3] & MSK_EVWARN;
    mdl[5] = mdl[3] & MSK_EVSEQ;
    mdl[6] = 8'($urandom);
    mdl[8] = RST_CFG;
    mdl[9] = {1'b0, RST_BASE};
    mdl[10] = RST_PERH;
    mdl[11] = {1'b0, RST_PERL};
    @(posedge pclk);
    live_status <= mdl[6];
    addr_sel <= 2'($urandom);
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    evt_main <= mdl[3];
    @(posedge pclk);
    evt_main <= 8'h00;
    repeat (12) @(posedge pclk);
    chk("per", 16'({RST_PERH, RST_PERL}), 16'(res_per));
    chk("toen", 16'h0001, 16'(to_en));
    apb(1'b0, 12'h010, 32'h0000_0000);
    chk("slverr", 16'h0001, 16'(pslverr));
    rd(8'h00, 12);
    tx(sad(1'b0) ^ 8'h02, 4'h3, 1'b1);
    addr_sel <= addr_sel + 2'h1;
    @(posedge pclk);
    d = '{mdl[3], 8'($urandom), 8'($urandom), 8'($urandom), 8'($urandom)};
    wr(REG_EVMAIN);
    chk("mask", 16'(mdl[7]), 16'(event_mask));
    d = '{8'h80};
    wr(REG_CFG);
    chk("toen", 16'h0000, 16'(to_en));
    rd(REG_PERH, 2);
    d = '{REG_PERH, 8'($urandom), 8'h0c, 8'($urandom), REG_PERL, 8'($urandom), REG_CFG, RST_CFG};
    tx(sad(1'b0), 4'h1, 1'b0);
    foreach (d[i]) begin
      tx(d[i], {2'b00, i == 7, 1'b0}, 1'b0);
      if (i % 2 == 1) upd(d[i - 1], d[i]);
    end
    chk("per", 16'({mdl[10], mdl[11][6:0]}), 16'(res_per));
    chk("toen", 16'h0001, 16'(to_en));
    rd(REG_EVMAIN, 9);
    give_verdict();
  end
endmodule // haptic_i2c_register_slave_bench

`default_nettype wire

/* File: verif/hir_monitor.sv */
`timescale 1ns/1ps
`default_nettype none

// ----
// Link watcher
// ----
module hir_monitor (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Link signals
  input wire logic m_scl_o,
  input wire logic m_scl_oe,
  input wire logic m_sda_o,
  input wire logic m_sda_oe,
  input wire logic d_sda_o,
  input wire logic d_sda_oe,
  input wire logic scl_line,
  input wire logic sda_line
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Set by a START, cleared by a STOP; the device must stay off the line outside.
  logic in_msg_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) in_msg_r <= 1'b0;
    else if (scl_line && $fell(sda_line)) in_msg_r <= 1'b1;
    else if (scl_line && $rose(sda_line)) in_msg_r <= 1'b0;
  end

  a_dev_pulls_only: assert property (d_sda_oe |-> !d_sda_o)
    else $error("device drives data high");
  a_mst_pulls_only: assert property ((m_sda_oe |-> !m_sda_o) and (m_scl_oe |-> !m_scl_o))
    else $error("controller drives a line high");
  a_start_by_mst: assert property (scl_line && $fell(sda_line) |-> m_sda_oe)
    else $error("start not made by controller");
  a_hold_scl_high: assert property (scl_line && $past(scl_line) |-> $stable(d_sda_oe))
    else $error("device data moved with clock high");
  a_edge_lag: assert property ($changed(d_sda_oe) |-> !scl_line && !$past(scl_line, 4))
    else $error("device data moved too soon after clock fall");
  a_ack_stands: assert property ($rose(d_sda_oe) |-> d_sda_oe [*8])
    else $error("device pull too short");
  a_stop_release: assert property (scl_line && $rose(sda_line) |-> !d_sda_oe [*8])
    else $error("device holds data after stop");
  a_idle_quiet: assert property (!in_msg_r |-> !d_sda_oe)
    else $error("device pulls data outside a message");
endmodule // hir_monitor

`default_nettype wire
